// ===== video_port_timestamp_unit.sv
// Timestamp unit top: registers, time base and four capture ports
// How it works
// - Frame-sync edge bit picks rising or falling
// - Tick field picks 40/80/160 ns or 1 us
// - Early-ready bit: ready once every enabled port's stamp present
// - Capture point bit: line start or frame
// - Hold freezes stamps and clears ready flag
// - Per-port enable bits gate each port's capture
// - Line mode captures at programmed 16-bit line
// - Free-run frame mode arms at programmed line
// - Line upper and lower bytes, read-write, zero
// - Free-run bit picks frame-sync or free-run
// - Status shows ready flag and port valids
// - Stamps read as byte pairs from 0x2A
module video_port_timestamp_unit
    import stamp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // Frame sync pin
    input wire logic frameSyncIn,
    // Receive port events
    input wire logic [stamp_pkg::NUM_PORTS-1:0] lineStart,
    input wire logic [stamp_pkg::NUM_PORTS-1:0] frameStart,
    // Status
    output logic stampsReady
);
    import stamp_pkg::*;

    logic [7:0] stampSetup_reg;
    logic [7:0] stampRunControl_reg;
    logic [7:0] lineUpper_reg;
    logic [7:0] lineLower_reg;
    logic fsSyncA_reg;
    logic fsSyncB_reg;
    logic fsSyncC_reg;
    logic [TICK_CNT_W-1:0] tickCnt_reg;
    logic [STAMP_W-1:0] timeNow_reg;
    logic [NUM_PORTS-1:0] portValid;
    logic [STAMP_W-1:0] portStamp [NUM_PORTS];

    logic edgeSelect;
    logic [1:0] tickSelect;
    logic earlyReady;
    logic freeRun;
    logic capturePoint;
    logic holdBit;
    logic [NUM_PORTS-1:0] portEnable;
    logic [STAMP_W-1:0] captureLine;
    logic wrRunControl;
    logic holdSet;
    logic holdRelease;
    logic fsRise;
    logic fsFall;
    logic fsEdge;
    logic [TICK_CNT_W-1:0] tickDiv;
    logic tick;
    logic periodEnd;
    logic allValid;
    logic readySet;
    logic ready_next;
    logic [3:0] resultIdx;
    logic [STAMP_W-1:0] resultWord;
    logic resultHit;
    logic [7:0] rdMux;

    assign edgeSelect = stampSetup_reg[FRAME_SYNC_EDGE_SELECT_BIT];
    assign tickSelect = stampSetup_reg[TICK_SELECT_MSB:TICK_SELECT_LSB];
    assign earlyReady = stampSetup_reg[EARLY_READY_SELECT_BIT];
    assign freeRun = stampSetup_reg[FREE_RUN_SELECT_BIT];
    assign capturePoint = stampSetup_reg[CAPTURE_POINT_SELECT_BIT];
    assign holdBit = stampRunControl_reg[STAMP_HOLD_BIT];
    assign portEnable = stampRunControl_reg[NUM_PORTS-1:0];
    assign captureLine = {lineUpper_reg, lineLower_reg};

    // Hold edges clear the ready flag; the release edge also clears the port valid flags
    assign wrRunControl = regWrite && (regAddr == STAMP_RUN_CONTROL_ADDR);
    assign holdSet = wrRunControl && regWrData[STAMP_HOLD_BIT] && !holdBit;
    assign holdRelease = wrRunControl && !regWrData[STAMP_HOLD_BIT] && holdBit;

    // Register writes; reserved bits masked off
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stampSetup_reg <= STAMP_SETUP_RESET;
            stampRunControl_reg <= STAMP_RUN_CONTROL_RESET;
            lineUpper_reg <= CAPTURE_LINE_RESET;
            lineLower_reg <= CAPTURE_LINE_RESET;
        end
        else if (regWrite)
        begin
            case (regAddr)
                STAMP_SETUP_ADDR: stampSetup_reg <= regWrData & STAMP_SETUP_WMASK;
                STAMP_RUN_CONTROL_ADDR: stampRunControl_reg <= regWrData & STAMP_RUN_CONTROL_WMASK;
                CAPTURE_LINE_UPPER_ADDR: lineUpper_reg <= regWrData;
                CAPTURE_LINE_LOWER_ADDR: lineLower_reg <= regWrData;
                default: ;
            endcase
        end
    end

    // Frame sync pin: two-stage synchroniser plus an edge stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fsSyncA_reg <= 1'b0;
            fsSyncB_reg <= 1'b0;
            fsSyncC_reg <= 1'b0;
        end
        else
        begin
            fsSyncA_reg <= frameSyncIn;
            fsSyncB_reg <= fsSyncA_reg;
            fsSyncC_reg <= fsSyncB_reg;
        end
    end

    assign fsRise = fsSyncB_reg && !fsSyncC_reg;
    assign fsFall = !fsSyncB_reg && fsSyncC_reg;
    assign fsEdge = edgeSelect ? fsFall : fsRise;

    // Time base
    assign tickDiv = (tickSelect == 2'b00) ? TICK0_CYC :
                     (tickSelect == 2'b01) ? TICK1_CYC :
                     (tickSelect == 2'b10) ? TICK2_CYC : TICK3_CYC;
    assign tick = (tickCnt_reg >= TICK_CNT_W'(tickDiv - 1'b1));
    assign periodEnd = freeRun ? (tick && (timeNow_reg == {STAMP_W{1'b1}})) : fsEdge;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tickCnt_reg <= '0;
            timeNow_reg <= '0;
        end
        else if (!freeRun && fsEdge)
        begin
            tickCnt_reg <= '0;
            timeNow_reg <= '0;
        end
        else if (tick)
        begin
            tickCnt_reg <= '0;
            timeNow_reg <= STAMP_W'(timeNow_reg + 1'b1);
        end
        else
            tickCnt_reg <= TICK_CNT_W'(tickCnt_reg + 1'b1);
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            port_stamp_capture u_capture (
                .clk(clk),
                .rst(rst),
                .enable(portEnable[p]),
                .hold(holdBit),
                .clearValid(holdRelease),
                .capturePoint(capturePoint),
                .freeRun(freeRun),
                .captureLine(captureLine),
                .timeNow(timeNow_reg),
                .lineStart(lineStart[p]),
                .frameStart(frameStart[p]),
                .stampValid(portValid[p]),
                .stamp(portStamp[p])
            );
        end
    endgenerate

    // Ready: early mode at once, normal mode at the period end
    assign allValid = (portEnable != '0) && ((portValid | ~portEnable) == {NUM_PORTS{1'b1}});
    assign readySet = allValid && (earlyReady || periodEnd);
    assign ready_next = !holdBit && !holdSet && !holdRelease && (stampsReady || readySet);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            stampsReady <= 1'b0;
        else
            stampsReady <= ready_next;
    end

    // Read path
    assign resultHit = (regAddr >= STAMP_RESULT_BASE_ADDR) && (regAddr <= STAMP_RESULT_LAST_ADDR);
    assign resultIdx = 4'(regAddr - STAMP_RESULT_BASE_ADDR);
    assign resultWord = portStamp[resultIdx[2:1]];

    always_comb
    begin
        rdMux = 8'h00;
        case (regAddr)
            STAMP_SETUP_ADDR: rdMux = stampSetup_reg;
            STAMP_RUN_CONTROL_ADDR: rdMux = stampRunControl_reg;
            CAPTURE_LINE_UPPER_ADDR: rdMux = lineUpper_reg;
            CAPTURE_LINE_LOWER_ADDR: rdMux = lineLower_reg;
            STAMP_STATE_ADDR: rdMux = {3'b000, stampsReady, portValid};
            default:
                if (resultHit)
                    rdMux = resultIdx[0] ? resultWord[7:0] : resultWord[15:8];
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            regRdData <= 8'h00;
        else if (regRead)
            regRdData <= rdMux;
    end

    property p_fs_restart;
        @(posedge clk) disable iff (rst) !freeRun && fsEdge |=> timeNow_reg == '0;
    endproperty
    a_fs_restart: assert property (p_fs_restart)
        else $error("time base not restarted by frame sync");

    property p_free_run_steady;
        @(posedge clk) disable iff (rst) freeRun && !tick |=> $stable(timeNow_reg);
    endproperty
    a_free_run_steady: assert property (p_free_run_steady)
        else $error("free-run time base moved off a tick");

    property p_tick_spacing;
        @(posedge clk) disable iff (rst) tickCnt_reg < tickDiv || $changed(tickSelect);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("tick divider out of range");

    property p_hold_clears_ready;
        @(posedge clk) disable iff (rst) holdSet |=> holdBit && !stampsReady;
    endproperty
    a_hold_clears_ready: assert property (p_hold_clears_ready)
        else $error("hold did not clear ready");

    property p_early_ready;
        @(posedge clk) disable iff (rst)
            earlyReady && allValid && !holdBit && !wrRunControl |=> stampsReady;
    endproperty
    a_early_ready: assert property (p_early_ready)
        else $error("early ready not raised");

    property p_line_upper_write;
        @(posedge clk) disable iff (rst)
            regWrite && regAddr == CAPTURE_LINE_UPPER_ADDR |=> lineUpper_reg == $past(regWrData);
    endproperty
    a_line_upper_write: assert property (p_line_upper_write)
        else $error("line upper byte not stored");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
            regRead && regAddr == STAMP_SETUP_ADDR |=> regRdData[7] == 1'b0 && regRdData[2] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved setup bits read nonzero");
endmodule

// ===== stamp_pkg.sv
// Shared constants for the video port timestamp unit
package stamp_pkg;
    localparam int NUM_PORTS = 4;
    localparam int STAMP_W = 16;

    // Register offsets
    localparam logic [7:0] STAMP_SETUP_ADDR = 8'h25;
    localparam logic [7:0] STAMP_RUN_CONTROL_ADDR = 8'h26;
    localparam logic [7:0] CAPTURE_LINE_UPPER_ADDR = 8'h27;
    localparam logic [7:0] CAPTURE_LINE_LOWER_ADDR = 8'h28;
    localparam logic [7:0] STAMP_STATE_ADDR = 8'h29;
    localparam logic [7:0] STAMP_RESULT_BASE_ADDR = 8'h2A;
    localparam logic [7:0] STAMP_RESULT_LAST_ADDR = 8'h31;

    // Reset values
    localparam logic [7:0] STAMP_SETUP_RESET = 8'h00;
    localparam logic [7:0] STAMP_RUN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] CAPTURE_LINE_RESET = 8'h00;

    // Field positions in stamp_setup
    localparam int FRAME_SYNC_EDGE_SELECT_BIT = 6;
    localparam int TICK_SELECT_MSB = 5;
    localparam int TICK_SELECT_LSB = 4;
    localparam int EARLY_READY_SELECT_BIT = 3;
    localparam int FREE_RUN_SELECT_BIT = 1;
    localparam int CAPTURE_POINT_SELECT_BIT = 0;
    localparam logic [7:0] STAMP_SETUP_WMASK = 8'h7B;

    // Field positions in stamp_run_control and stamp_state
    localparam int STAMP_HOLD_BIT = 4;
    localparam logic [7:0] STAMP_RUN_CONTROL_WMASK = 8'h1F;
    localparam int STAMPS_READY_BIT = 4;

    // Tick resolutions and derived cycle counts
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK0_NS = 40;
    localparam int TICK1_NS = 80;
    localparam int TICK2_NS = 160;
    localparam int TICK3_NS = 1000;
    localparam int TICK_CNT_W = 7;
    localparam logic [TICK_CNT_W-1:0] TICK0_CYC = TICK_CNT_W'(TICK0_NS / CLK_PERIOD_NS);
    localparam logic [TICK_CNT_W-1:0] TICK1_CYC = TICK_CNT_W'(TICK1_NS / CLK_PERIOD_NS);
    localparam logic [TICK_CNT_W-1:0] TICK2_CYC = TICK_CNT_W'(TICK2_NS / CLK_PERIOD_NS);
    localparam logic [TICK_CNT_W-1:0] TICK3_CYC = TICK_CNT_W'(TICK3_NS / CLK_PERIOD_NS);
endpackage

// ===== port_stamp_capture.sv
// Per receive port line counting and timestamp capture
module port_stamp_capture
    import stamp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic enable,
    input wire logic hold,
    input wire logic clearValid,
    input wire logic capturePoint,
    input wire logic freeRun,
    input wire logic [STAMP_W-1:0] captureLine,
    input wire logic [STAMP_W-1:0] timeNow,
    // Receive port events
    input wire logic lineStart,
    input wire logic frameStart,
    // Result
    output logic stampValid,
    output logic [STAMP_W-1:0] stamp
);
    logic [STAMP_W-1:0] lineCount_reg;
    logic armed_reg;
    logic [STAMP_W-1:0] nextLine;
    logic lineHit;
    logic lineReached;
    logic frameHit;
    logic captureNow;

    assign nextLine = STAMP_W'(lineCount_reg + 1'b1);
    assign lineHit = lineStart && (nextLine == captureLine);
    assign lineReached = lineStart && (nextLine >= captureLine);
    // Free-run frame mode looks for frame start only after the line is reached
    assign frameHit = frameStart && (!freeRun || armed_reg);
    assign captureNow = enable && !hold && (capturePoint ? frameHit : lineHit);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lineCount_reg <= '0;
            armed_reg <= 1'b0;
        end
        else if (frameStart)
        begin
            lineCount_reg <= '0;
            armed_reg <= 1'b0;
        end
        else if (lineStart)
        begin
            if (lineCount_reg != {STAMP_W{1'b1}})
                lineCount_reg <= nextLine;
            if (lineReached)
                armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stamp <= '0;
            stampValid <= 1'b0;
        end
        else
        begin
            if (captureNow)
                stamp <= timeNow;
            // A capture in the clearing cycle is kept
            stampValid <= captureNow | (stampValid & ~clearValid);
        end
    end

    property p_disabled_frozen;
        @(posedge clk) disable iff (rst) !enable |=> $stable(stamp);
    endproperty
    a_disabled_frozen: assert property (p_disabled_frozen)
        else $error("stamp changed while port disabled");

    property p_hold_frozen;
        @(posedge clk) disable iff (rst) hold |=> $stable(stamp);
    endproperty
    a_hold_frozen: assert property (p_hold_frozen)
        else $error("stamp changed while held");

    property p_line_capture;
        @(posedge clk) disable iff (rst)
            enable && !hold && !capturePoint && lineHit
            |=> stampValid && stamp == $past(timeNow);
    endproperty
    a_line_capture: assert property (p_line_capture)
        else $error("line start capture missed");

    property p_frame_capture;
        @(posedge clk) disable iff (rst)
            enable && !hold && capturePoint && !freeRun && frameStart
            |=> stampValid && stamp == $past(timeNow);
    endproperty
    a_frame_capture: assert property (p_frame_capture)
        else $error("frame start capture missed");
endmodule

// ===== video_port_timestamp_unit_tb.sv
// Self-checking bench for the video port timestamp unit
module video_port_timestamp_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import stamp_pkg::*;
    logic clk, rst, regWrite, regRead, frameSyncIn, stampsReady;
    logic [7:0] regAddr, regWrData, regRdData, rdVal;
    logic [NUM_PORTS-1:0] lineStart, frameStart;
    logic [STAMP_W-1:0] stamps [NUM_PORTS];
    logic [31:0] rnd;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    video_port_timestamp_unit video_port_timestamp_unit_i (.clk(clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .frameSyncIn(frameSyncIn), .lineStart(lineStart),
        .frameStart(frameStart), .stampsReady(stampsReady));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int tick_div(input logic [1:0] c);
        return (c == 2'd0 ? TICK0_NS : c == 2'd1 ? TICK1_NS : c == 2'd2 ? TICK2_NS : TICK3_NS)
            / CLK_PERIOD_NS;
    endfunction

    function automatic logic [7:0] reg_exp(input logic [7:0] a, input logic [7:0] d);
        return a == 8'h25 ? d & 8'h7B : a == 8'h26 ? d & 8'h1F : (a == 8'h27 || a == 8'h28) ? d
            : 8'h00;
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        rdVal = regRdData;
    endtask

    // Hold then release, which empties the valid flags
    task automatic clr(input logic [3:0] en);
        wr(STAMP_RUN_CONTROL_ADDR, {4'h1, en});
        wr(STAMP_RUN_CONTROL_ADDR, {4'h0, en});
    endtask

    task automatic pulse(input logic ls, input logic fs, input int gap);
        repeat (gap) @(posedge clk);
        lineStart <= {NUM_PORTS{ls}};
        frameStart <= {NUM_PORTS{fs}};
        @(posedge clk);
        lineStart <= '0;
        frameStart <= '0;
    endtask

    // Active edge preceded by an inactive one
    task automatic fs_edge(input logic pol, input int gap, output realtime t0);
        @(posedge clk);
        frameSyncIn <= ~pol;
        repeat (4) @(posedge clk);
        frameSyncIn <= pol;
        repeat (gap) @(posedge clk);
        frameSyncIn <= ~pol;
        t0 = $time;
    endtask

    // Line mode: F L L L; frame mode: L L L F; the last event captures
    task automatic events(input logic mode, input int gap, output realtime tc);
        for (int i = 0; i < 4; i++)
        begin
            tc = $time + gap * 8;
            pulse(mode ? i < 3 : i > 0, mode ? i == 3 : i == 0, gap);
        end
    endtask

    task automatic round(input logic [1:0] tick, input logic pol, input logic mode,
        input logic early, input logic [3:0] en);
        int dv;
        int ex;
        int s;
        realtime t0, tc;
        logic [15:0] old;
        dv = tick_div(tick);
        wr(CAPTURE_LINE_UPPER_ADDR, 8'h00);
        wr(CAPTURE_LINE_LOWER_ADDR, 8'h03);
        wr(STAMP_SETUP_ADDR, {1'b0, pol, tick, early, 2'b00, mode});
        clr(en);
        fs_edge(pol, 3 * dv + 8, t0);
        events(mode, dv * (2 + int'(rnd[10:8]) % 6), tc);
        ex = (int'((tc - t0) / 8.0) - 3) / dv;
        repeat (3) @(posedge clk);
        rd(STAMP_STATE_ADDR);
        chk("early status", {11'h0, early, en}, {8'h0, rdVal});
        if (!early)
        begin
            fs_edge(pol, 4, t0);
            repeat (10) @(posedge clk);
            rd(STAMP_STATE_ADDR);
            chk("period status", {11'h1, en}, {8'h0, rdVal});
        end
        chk("stampsReady", 16'h1, {15'h0, stampsReady});
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            old = stamps[p];
            rd(STAMP_RESULT_BASE_ADDR + 8'(2 * p));
            stamps[p][15:8] = rdVal;
            rd(STAMP_RESULT_BASE_ADDR + 8'(2 * p + 1));
            stamps[p][7:0] = rdVal;
            s = int'(stamps[p]);
            if (!en[p])
                chk("disabled stamp", old, stamps[p]);
            else
            begin
                comparisons++;
                if (s != ex)
                begin
                    mismatches++;
                    $display("unexpected stamp %0d: expected %0d, seen %0d", p, ex, s);
                end
            end
        end
        wr(STAMP_RUN_CONTROL_ADDR, {4'h1, en});
        @(posedge clk);
        chk("held ready", 16'h0, {15'h0, stampsReady});
        events(mode, 6, tc);
        repeat (3) @(posedge clk);
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            rd(STAMP_RESULT_BASE_ADDR + 8'(2 * p + 1));
            chk("held stamp", {8'h0, stamps[p][7:0]}, {8'h0, rdVal});
        end
        rd(STAMP_STATE_ADDR);
        chk("held status", {12'h0, en}, {8'h0, rdVal});
        wr(STAMP_RUN_CONTROL_ADDR, {4'h0, en});
        rd(STAMP_STATE_ADDR);
        chk("released status", 16'h0, {8'h0, rdVal});
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    initial
    begin
        logic [7:0] addrs [7];
        realtime tc;
        addrs = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h20};
        rst = 1'b1;
        regAddr = '0;
        regWrData = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        frameSyncIn = 1'b0;
        lineStart = '0;
        frameStart = '0;
        rnd = 32'h6d21;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int a = 8'h20; a <= 8'h31; a++)
        begin
            rd(8'(a));
            chk("reset value", 16'h0, {8'h0, rdVal});
        end
        foreach (addrs[k])
        begin
            rnd = lfsr(rnd);
            wr(addrs[k], rnd[7:0]);
            rd(addrs[k]);
            chk("readback", {8'h0, reg_exp(addrs[k], rnd[7:0])}, {8'h0, rdVal});
        end
        for (int r = 0; r < 8; r++)
        begin
            rnd = lfsr(rnd);
            round(2'(r), r[0] ^ r[2], r[2], r == 1 ? 1'b0 : r == 0 || rnd[2],
                r == 0 ? 4'hF : rnd[7:4] | 4'h1);
        end
        wr(STAMP_SETUP_ADDR, 8'h0B);
        events(1'b0, 8, tc);
        clr(4'hF);
        pulse(1'b0, 1'b1, 8);
        repeat (3) @(posedge clk);
        rd(STAMP_STATE_ADDR);
        chk("armed capture", 16'h1F, {8'h0, rdVal});
        clr(4'hF);
        pulse(1'b0, 1'b1, 8);
        repeat (3) @(posedge clk);
        rd(STAMP_STATE_ADDR);
        chk("unarmed capture", 16'h0, {8'h0, rdVal});
        print_verdict();
    end
endmodule
